// ===== hw/alf_fault_resp.sv
// Purpose: Fault-response configuration for two analog input channels and temp fan masks
// Assumes: Threshold comparison flags come from logic on MCLK_IN; a bus engine drives
//          the register port with one-cycle strobes
// Notes:   Outputs are registered, so responses follow the flags by one cycle
`timescale 1ns/100ps
`include "alf_map.svh"

// Functional notes
// - Temp fan mask bits 2-7 read zero
// - Offsets 48h/49h/4Ah serve local, remote one, two
// - Offset 50h first channel, 51h second
// - Bit 0: cascade fault above upper threshold
// - Bit 1: alarm speed above upper threshold
// - Bit 2: host alert above upper threshold
// - Bit 3 selects lower threshold fault sense
// - Bit 4: cascade fault on lower threshold
// - Bit 5: alarm speed on lower threshold
// - Bit 6: host alert on lower threshold
// - Bit 7 latches any out-of-limit event
// - Latch clears on reset or when host writes zero
// - Channel fan masks choose fans for alarm
// - Alarm speed from fan speed upper nibble
module alf_fault_resp #(
  parameter int N_CH  = 2,
  parameter int N_FAN = 2
) (
  input  wire logic                   MCLK_IN,         // 100 MHz clock
  input  wire logic                   SRST_IN,         // Synchronous reset, active high
  input  wire logic                   CE_IN,           // Clock enable, freezes state when low
  input  wire logic [`ALF_ADDR_W-1:0] REG_ADDR_IN,     // Register offset
  input  wire logic [`ALF_DATA_W-1:0] REG_WDATA_IN,    // Write data
  input  wire logic                   REG_WR_IN,       // Write strobe, one cycle
  input  wire logic                   REG_RD_IN,       // Read strobe, one cycle
  input  wire logic [N_CH-1:0]        ABOVE_UPPER_IN,  // Reading above upper threshold
  input  wire logic [N_CH-1:0]        ABOVE_LOWER_IN,  // Reading above lower threshold
  input  wire logic [N_CH-1:0]        BELOW_LOWER_IN,  // Reading below lower threshold
  input  wire logic [N_FAN*8-1:0]     FAN_SPEED_IN,    // Fan speed registers, fan 0 low byte
  output logic [`ALF_DATA_W-1:0]      REG_RDATA_OUT,   // Read data, valid after read strobe
  output logic                        REG_RVALID_OUT,  // Read data valid pulse
  output logic                        CASCADE_FAULT_OUT_N_OUT,    // Cascade fault, active low
  output logic                        ALERT_N_OUT,     // Host alert, active low
  output logic [N_FAN-1:0]            FAN_ALARM_OUT,   // Fan forced to alarm speed
  output logic [N_FAN*4-1:0]          FAN_ALARM_SPD_OUT // Alarm speed nibble per fan
);

  localparam int NIB = `ALF_ALARM_MSB - `ALF_ALARM_LSB + 1;

  alf_pkg::alf_resp_t           resp_q [N_CH];
  alf_pkg::alf_resp_t           resp_d [N_CH];
  logic [1:0]                   ain_mask_q [N_CH];
  logic [1:0]                   ain_mask_d [N_CH];
  logic [1:0]                   tmp_mask_q [3];
  logic [1:0]                   tmp_mask_d [3];
  alf_pkg::alf_chan_evt_t       evt [N_CH];
  logic [`ALF_DATA_W-1:0]       rdata_d;
  logic [`ALF_DATA_W-1:0]       rdata_q;
  logic                         rvalid_d;
  logic                         rvalid_q;
  logic                         cascade_fault_out_n_d;
  logic                         cascade_fault_out_n_q;
  logic                         alert_n_d;
  logic                         alert_n_q;
  logic [N_FAN-1:0]             alarm_d;
  logic [N_FAN-1:0]             alarm_q;
  logic [N_FAN*4-1:0]           spd_d;
  logic [N_FAN*4-1:0]           spd_q;

  // Evaluates one channel's configured responses against its comparison flags
  function automatic alf_pkg::alf_chan_evt_t chan_eval(
    input alf_pkg::alf_resp_t r,
    input logic               hi,
    input logic               lo_above,
    input logic               lo_below
  );
    alf_pkg::alf_chan_evt_t e;
    logic                   lo;
    lo          = r.above_lo ? lo_above : lo_below;
    e.cascade_fault_out    = (r.cascade_fault_out_hi & hi) | (r.cascade_fault_out_lo & lo);
    e.alarm     = (r.alarm_hi & hi) | (r.alarm_lo & lo);
    e.alert     = (r.alert_hi & hi) | (r.alert_lo & lo);
    e.event_hit = hi | lo;
    return e;
  endfunction

  function automatic logic [`ALF_DATA_W-1:0] mask_rd(input logic [1:0] m);
    return {6'h00, m} & `ALF_MASK_USED;
  endfunction

  always_comb
  begin
    for (int c = 0; c < N_CH; c++)
    begin
      evt[c] = chan_eval(resp_q[c], ABOVE_UPPER_IN[c], ABOVE_LOWER_IN[c], BELOW_LOWER_IN[c]);
    end
  end

  // Bit 7 is cleared by reset or by a host write of zero; writing a one keeps its current value
  function automatic alf_pkg::alf_resp_t resp_wr(
    input alf_pkg::alf_resp_t     old,
    input logic [`ALF_DATA_W-1:0] wd
  );
    return alf_pkg::alf_resp_t'({old.latch & wd[`ALF_LATCH_BIT],
                                 wd[`ALF_LATCH_BIT-1:0]});
  endfunction

  // Temperature-channel fan masks: stored and readable, they steer nothing here
  always_comb
  begin
    for (int t = 0; t < 3; t++)
    begin
      tmp_mask_d[t] = tmp_mask_q[t];
    end
    if (REG_WR_IN)
    begin
      unique case (REG_ADDR_IN)
        `ALF_OFS_LOCAL_MASK: tmp_mask_d[0] = REG_WDATA_IN[1:0];
        `ALF_OFS_REM1_MASK:  tmp_mask_d[1] = REG_WDATA_IN[1:0];
        `ALF_OFS_REM2_MASK:  tmp_mask_d[2] = REG_WDATA_IN[1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (SRST_IN)
    begin
      for (int t = 0; t < 3; t++)
      begin
        tmp_mask_q[t] <= 2'h0;
      end
    end
    else if (CE_IN)
    begin
      tmp_mask_q <= tmp_mask_d;
    end
  end

  // Analog channel fan masks; only the two fan bits are kept
  always_comb
  begin
    for (int c = 0; c < N_CH; c++)
    begin
      ain_mask_d[c] = ain_mask_q[c];
    end
    if (REG_WR_IN)
    begin
      unique case (REG_ADDR_IN)
        `ALF_OFS_ANALOG_INPUT_FIRST_MASK:  ain_mask_d[0] = REG_WDATA_IN[1:0];
        `ALF_OFS_ANALOG_INPUT_SECOND_MASK:  ain_mask_d[1] = REG_WDATA_IN[1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (SRST_IN)
    begin
      for (int c = 0; c < N_CH; c++)
      begin
        ain_mask_q[c] <= 2'h0;
      end
    end
    else if (CE_IN)
    begin
      ain_mask_q <= ain_mask_d;
    end
  end

  // Fault-response registers and their latched event bit
  always_comb
  begin
    for (int c = 0; c < N_CH; c++)
    begin
      resp_d[c] = resp_q[c];
    end
    if (REG_WR_IN)
    begin
      unique case (REG_ADDR_IN)
        `ALF_OFS_ANALOG_INPUT_FIRST_RESP:  resp_d[0] = resp_wr(resp_q[0], REG_WDATA_IN);
        `ALF_OFS_ANALOG_INPUT_SECOND_RESP:  resp_d[1] = resp_wr(resp_q[1], REG_WDATA_IN);
        default: ;
      endcase
    end
    // Set after the write so an event in the clearing cycle is kept
    for (int c = 0; c < N_CH; c++)
    begin
      if (evt[c].event_hit)
      begin
        resp_d[c].latch = 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (SRST_IN)
    begin
      for (int c = 0; c < N_CH; c++)
      begin
        resp_q[c] <= alf_pkg::alf_resp_t'(`ALF_RESET_VAL);
      end
    end
    else if (CE_IN)
    begin
      resp_q <= resp_d;
    end
  end

  // Read path, answered one cycle after the strobe; data holds until the next read
  always_comb
  begin
    rdata_d  = rdata_q;
    rvalid_d = REG_RD_IN;
    if (REG_RD_IN)
    begin
      unique case (REG_ADDR_IN)
        `ALF_OFS_LOCAL_MASK: rdata_d = mask_rd(tmp_mask_q[0]);
        `ALF_OFS_REM1_MASK:  rdata_d = mask_rd(tmp_mask_q[1]);
        `ALF_OFS_REM2_MASK:  rdata_d = mask_rd(tmp_mask_q[2]);
        `ALF_OFS_ANALOG_INPUT_FIRST_RESP:  rdata_d = resp_q[0];
        `ALF_OFS_ANALOG_INPUT_SECOND_RESP:  rdata_d = resp_q[1];
        `ALF_OFS_ANALOG_INPUT_FIRST_MASK:  rdata_d = {6'h00, ain_mask_q[0]};
        `ALF_OFS_ANALOG_INPUT_SECOND_MASK:  rdata_d = {6'h00, ain_mask_q[1]};
        default:             rdata_d = `ALF_RESET_VAL;
      endcase
    end
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (SRST_IN)
    begin
      rdata_q  <= `ALF_RESET_VAL;
      rvalid_q <= 1'b0;
    end
    else if (CE_IN)
    begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // Response outputs follow the flags, not the latch, so they drop with the condition
  // Alarm speed follows the fan register even while idle
  always_comb
  begin
    cascade_fault_out_n_d = `ALF_OUT_IDLE;
    alert_n_d  = `ALF_OUT_IDLE;
    alarm_d    = '0;
    for (int c = 0; c < N_CH; c++)
    begin
      if (evt[c].cascade_fault_out)
      begin
        cascade_fault_out_n_d = ~`ALF_OUT_IDLE;
      end
      if (evt[c].alert)
      begin
        alert_n_d = ~`ALF_OUT_IDLE;
      end
      if (evt[c].alarm)
      begin
        alarm_d = alarm_d | ain_mask_q[c][N_FAN-1:0];
      end
    end
    for (int f = 0; f < N_FAN; f++)
    begin
      spd_d[f*NIB +: NIB] = FAN_SPEED_IN[f*8+`ALF_ALARM_LSB +: NIB];
    end
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (SRST_IN)
    begin
      cascade_fault_out_n_q <= `ALF_OUT_IDLE;
      alert_n_q  <= `ALF_OUT_IDLE;
      alarm_q    <= '0;
      spd_q      <= '0;
    end
    else if (CE_IN)
    begin
      cascade_fault_out_n_q <= cascade_fault_out_n_d;
      alert_n_q  <= alert_n_d;
      alarm_q    <= alarm_d;
      spd_q      <= spd_d;
    end
  end

  assign REG_RDATA_OUT     = rdata_q;
  assign REG_RVALID_OUT    = rvalid_q;
  assign CASCADE_FAULT_OUT_N_OUT      = cascade_fault_out_n_q;
  assign ALERT_N_OUT       = alert_n_q;
  assign FAN_ALARM_OUT     = alarm_q;
  assign FAN_ALARM_SPD_OUT = spd_q;

endmodule

// ===== hw/alf_map.svh
// Purpose: Register offsets, field positions and reset values of the fault-response bank
// Assumes: 8-bit register offsets as seen by the serial management bus engine
// Notes:   Definitions only
`ifndef ALF_MAP_SVH
`define ALF_MAP_SVH

`define ALF_ADDR_W          8
`define ALF_DATA_W          8
`define ALF_OFS_LOCAL_MASK  8'h48
`define ALF_OFS_REM1_MASK   8'h49
`define ALF_OFS_REM2_MASK   8'h4a
`define ALF_OFS_ANALOG_INPUT_FIRST_RESP   8'h50
`define ALF_OFS_ANALOG_INPUT_SECOND_RESP   8'h51
`define ALF_OFS_ANALOG_INPUT_FIRST_MASK   8'h58
`define ALF_OFS_ANALOG_INPUT_SECOND_MASK   8'h59
`define ALF_RESET_VAL       8'h00
`define ALF_MASK_USED       8'h03
`define ALF_LATCH_BIT       7
`define ALF_ALARM_MSB       7
`define ALF_ALARM_LSB       4
`define ALF_OUT_IDLE        1'b1

`endif

// ===== hw/alf_pkg.sv
// Purpose: Types shared by the fault-response bank
// Assumes: Field layout of a channel fault-response register, bit 0 lowest
// Notes:   Offsets and reset values live in alf_map.svh
package alf_pkg;

  typedef struct packed {
    logic latch;      // Bit 7: latched out-of-limit event
    logic alert_lo;   // Bit 6: host alert on lower threshold
    logic alarm_lo;   // Bit 5: alarm speed on lower threshold
    logic cascade_fault_out_lo;  // Bit 4: cascade fault on lower threshold
    logic above_lo;   // Bit 3: 1 = above lower threshold is a fault
    logic alert_hi;   // Bit 2: host alert on upper threshold
    logic alarm_hi;   // Bit 1: alarm speed on upper threshold
    logic cascade_fault_out_hi;  // Bit 0: cascade fault on upper threshold
  } alf_resp_t;

  typedef struct packed {
    logic cascade_fault_out;
    logic alert;
    logic alarm;
    logic event_hit;
  } alf_chan_evt_t;

endpackage

// ===== verif/alf_fault_resp_assertions.sv
// Purpose: Port-level checks for the fault-response bank
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every alf_fault_resp instance
`timescale 1ns/100ps
`include "alf_map.svh"
module alf_fault_resp_assertions #(
  parameter int N_CH  = 2,
  parameter int N_FAN = 2
) (
  input wire logic                   MCLK_IN, SRST_IN, CE_IN, REG_WR_IN, REG_RD_IN,
  input wire logic [`ALF_ADDR_W-1:0] REG_ADDR_IN,
  input wire logic [`ALF_DATA_W-1:0] REG_WDATA_IN, REG_RDATA_OUT,
  input wire logic [N_CH-1:0]        ABOVE_UPPER_IN, ABOVE_LOWER_IN, BELOW_LOWER_IN,
  input wire logic [N_FAN*8-1:0]     FAN_SPEED_IN,
  input wire logic                   REG_RVALID_OUT, CASCADE_FAULT_OUT_N_OUT, ALERT_N_OUT,
  input wire logic [N_FAN-1:0]       FAN_ALARM_OUT,
  input wire logic [N_FAN*4-1:0]     FAN_ALARM_SPD_OUT
);
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (SRST_IN);
  logic [N_CH-1:0] any_flag;
  assign any_flag = ABOVE_UPPER_IN | ABOVE_LOWER_IN | BELOW_LOWER_IN;
  sequence rd_take;
    CE_IN && REG_RD_IN;
  endsequence
  sequence mask_rd;
    rd_take ##0 (REG_ADDR_IN inside {`ALF_OFS_LOCAL_MASK, `ALF_OFS_REM1_MASK,
                 `ALF_OFS_REM2_MASK, `ALF_OFS_ANALOG_INPUT_FIRST_MASK, `ALF_OFS_ANALOG_INPUT_SECOND_MASK});
  endsequence
  rvalid_pulse_a: assert property (rd_take |=> REG_RVALID_OUT)
    else $error("read strobe gave no valid pulse");
  mask_read_a: assert property (mask_rd |=> REG_RDATA_OUT[7:2] == 6'h00)
    else $error("fan mask upper bits read nonzero");
  unmapped_read_a: assert property (rd_take ##0 !(REG_ADDR_IN inside {8'h48, 8'h49, 8'h4a,
    8'h50, 8'h51, 8'h58, 8'h59}) |=> REG_RDATA_OUT == 8'h00)
    else $error("unmapped read nonzero");
  idle_out_a: assert property (CE_IN && any_flag == '0 |=> CASCADE_FAULT_OUT_N_OUT && ALERT_N_OUT)
    else $error("outputs not idle high");
  spd_pass_a: assert property (CE_IN |=> FAN_ALARM_SPD_OUT ==
    {$past(FAN_SPEED_IN[15:12]), $past(FAN_SPEED_IN[7:4])})
    else $error("alarm speed nibble wrong");
  alarm_cause_a: assert property (FAN_ALARM_OUT != '0 |-> $past(any_flag) != '0)
    else $error("alarm without flag");
  cascade_fault_out_cause_a: assert property ($fell(CASCADE_FAULT_OUT_N_OUT) |-> $past(any_flag) != '0)
    else $error("cascade fault without flag");
  alert_cause_a: assert property (!ALERT_N_OUT |-> $past(any_flag) != '0)
    else $error("alert without flag");
endmodule

bind alf_fault_resp alf_fault_resp_assertions #(.N_CH(N_CH), .N_FAN(N_FAN)) u_chk (
  .MCLK_IN(MCLK_IN), .SRST_IN(SRST_IN), .CE_IN(CE_IN), .REG_WR_IN(REG_WR_IN),
  .REG_RD_IN(REG_RD_IN), .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN),
  .REG_RDATA_OUT(REG_RDATA_OUT), .ABOVE_UPPER_IN(ABOVE_UPPER_IN),
  .ABOVE_LOWER_IN(ABOVE_LOWER_IN), .BELOW_LOWER_IN(BELOW_LOWER_IN),
  .FAN_SPEED_IN(FAN_SPEED_IN), .REG_RVALID_OUT(REG_RVALID_OUT), .CASCADE_FAULT_OUT_N_OUT(CASCADE_FAULT_OUT_N_OUT),
  .ALERT_N_OUT(ALERT_N_OUT), .FAN_ALARM_OUT(FAN_ALARM_OUT),
  .FAN_ALARM_SPD_OUT(FAN_ALARM_SPD_OUT));

// ===== verif/alf_fault_resp_tb.sv
// Purpose: Register and fault-path tests of the fault-response bank
// Assumes: Inputs change on falling edges
// Notes:   Table rows are {chan, config, flags au/al/bl, cascade_fault_out_n alert_n alarm[1:0]}
`timescale 1ns/100ps
`include "alf_map.svh"
module alf_fault_resp_tb;
  logic clk = 0, rst = 1, ce = 1, wr, rd, rvalid, cf_n, al_n;
  logic [7:0] addr, wdata, rdata, spd_out, d, cfg;
  logic [1:0] au = 0, al = 0, bl = 0, alarm;
  logic [3:0] ch, flg, ex;
  int num_errors = 0, comparisons = 0;
  logic [7:0] ofs [7] = '{8'h48, 8'h49, 8'h4a, 8'h50, 8'h51, 8'h58, 8'h59};
  logic [19:0] tbl [9] = '{20'h00144, 20'h0024d, 20'h00448, 20'h01014, 20'h01824,
                           20'h0181c, 20'h0201d, 20'h04018, 20'h1024e};
  alf_host_model u_host (.clk_in(clk), .rvalid_in(rvalid), .rdata_in(rdata),
    .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
  alf_fault_resp u_dut (.MCLK_IN(clk), .SRST_IN(rst), .CE_IN(ce), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .ABOVE_UPPER_IN(au),
    .ABOVE_LOWER_IN(al), .BELOW_LOWER_IN(bl), .FAN_SPEED_IN(16'ha5c3), .REG_RDATA_OUT(rdata),
    .REG_RVALID_OUT(rvalid), .CASCADE_FAULT_OUT_N_OUT(cf_n), .ALERT_N_OUT(al_n), .FAN_ALARM_OUT(alarm),
    .FAN_ALARM_SPD_OUT(spd_out));
  initial forever #5 clk = ~clk;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    @(negedge clk) rst = 0;
    foreach (ofs[i]) begin u_host.rd_reg(ofs[i], d); check(d, 8'h00); end
    for (int i = 0; i < 3; i++)
    begin
      u_host.wr_reg(ofs[i], 8'hfd + 8'(i));
      u_host.rd_reg(ofs[i], d); check(d, 8'(i + 1));
    end
    u_host.wr_reg(8'h50, 8'h80); u_host.rd_reg(8'h50, d); check(d, 8'h00);
    u_host.wr_reg(8'h51, 8'h5a); u_host.rd_reg(8'h51, d); check(d, 8'h5a);
    @(negedge clk) ce = 0;
    u_host.wr_reg(8'h51, 8'h00);
    ce = 1;
    u_host.rd_reg(8'h51, d); check(d, 8'h5a);
    u_host.wr_reg(8'h52, 8'h33); u_host.rd_reg(8'h52, d); check(d, 8'h00);
    u_host.wr_reg(8'h58, 8'h01);
    u_host.wr_reg(8'h59, 8'h02);
    foreach (tbl[k])
    begin
      {ch, cfg, flg, ex} = tbl[k];
      u_host.wr_reg(8'h50 + {4'h0, ch}, cfg);
      @(negedge clk) {au[ch[0]], al[ch[0]], bl[ch[0]]} = flg[2:0];
      @(negedge clk) check({4'h0, cf_n, al_n, alarm}, {4'h0, ex});
      {au, al, bl} = 6'h00;
      u_host.rd_reg(8'h50 + {4'h0, ch}, d);
      check(d, {flg[2] | (cfg[3] ? flg[1] : flg[0]), cfg[6:0]});
      u_host.wr_reg(8'h50 + {4'h0, ch}, cfg);
      u_host.rd_reg(8'h50 + {4'h0, ch}, d); check(d, cfg);
    end
    check(spd_out, 8'hac);
    report_and_stop();
  end
  initial
  begin
    #100000;
    num_errors++;
    report_and_stop();
  end
endmodule

// ===== verif/alf_host_model.sv
// Purpose: Host side of the register port, one-cycle strobes on falling edges
// Assumes: Read answer comes one edge after the taking edge
// Notes:   Released lines show the inverse so stale values are never trusted
`timescale 1ns/100ps
module alf_host_model (
  input  wire logic       clk_in, rvalid_in,
  input  wire logic [7:0] rdata_in,
  output logic [7:0]      addr_out, wdata_out,
  output logic            wr_out, rd_out
);
  initial {addr_out, wdata_out, wr_out, rd_out} = 18'h0;
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    {addr_out, wdata_out, wr_out} = {a, d, 1'b1}; // Zero in bit 7 clears the latch
    @(negedge clk_in);
    {addr_out, wdata_out, wr_out} = {~a, ~d, 1'b0};
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    d = 8'hxx;
    @(negedge clk_in);
    {addr_out, rd_out} = {a, 1'b1};
    @(negedge clk_in);
    {addr_out, rd_out} = {~a, 1'b0};
    // Taken at the last rising edge, the one-cycle answer stands until the next
    if (rvalid_in === 1'b1)
    begin
      d = rdata_in;
    end
  endtask
endmodule
